// >>> verilog/low_leak_wake_unit.sv
// Purpose: low-leakage wake unit with two pin glitch filters and wake response
// Assumes: power_mode_in from the mode controller, pins synchronous to clk_in
// Notes: deep_wake_reset_in high during reset marks a reset caused by deep wake
`timescale 1ns/1ps
`default_nettype none

module low_leak_wake_unit #(
   parameter int LPO_DIV = low_leak_wake_pkg::LPO_DIV_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic deep_wake_reset_in,
   input wire logic [1:0] power_mode_in,
   input wire logic [15:0] wake_pins_in,
   input wire logic [7:0] module_wake_req_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [7:0] rd_data_out,
   output logic wake_irq_out,
   output logic wake_reset_out,
   output logic io_isolate_out
);

   logic chip_reset;
   logic low_leak;
   logic in_lls;
   logic in_vlls;
   logic wake_any;
   logic lpo_tick;
   logic [15:0] lpo_cnt;
   logic [1:0] pin_edge [low_leak_wake_pkg::PINS];
   logic [15:0] pins_prev;
   logic [15:0] pin_hit;
   logic [15:0] pin_flag;
   logic [7:0] module_wake_enable;
   logic [7:0] module_hit;
   logic reset_status_wake_flag;
   logic [1:0] filter_edge_select [low_leak_wake_pkg::FILTERS];
   logic [3:0] filter_pin_select [low_leak_wake_pkg::FILTERS];
   logic [1:0] filter_detect_flag;
   logic [1:0] filt_det;
   logic wr_filt_one;
   logic wr_filt_two;
   logic [1:0] filt_wr;
   logic [7:0] next_rd_data;

   // a deep-wake reset leaves the filter registers and isolation state alone
   assign chip_reset = !rst_n_in && !deep_wake_reset_in;
   assign low_leak = power_mode_in != low_leak_wake_pkg::MODE_RUN;
   assign in_lls = power_mode_in == low_leak_wake_pkg::MODE_LLS;
   assign in_vlls = power_mode_in[1];
   assign wr_filt_one = wr_en_in && addr_in == low_leak_wake_pkg::ADDR_FILT_ONE;
   assign wr_filt_two = wr_en_in && addr_in == low_leak_wake_pkg::ADDR_FILT_TWO;
   assign filt_wr = {wr_filt_two, wr_filt_one};

   ////////////////////////////////////////////////////////////////////////////
   // low-power clock stand-in: one-cycle enable from a divider
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lpo_cnt <= 16'h0000;
         lpo_tick <= 1'b0;
      end else if (lpo_cnt == 16'(LPO_DIV - 1)) begin
         lpo_cnt <= 16'h0000;
         lpo_tick <= 1'b1;
      end else begin
         lpo_cnt <= 16'(lpo_cnt + 16'h0001);
         lpo_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the two filters
   genvar g;
   generate
      for (g = 0; g < low_leak_wake_pkg::FILTERS; g++) begin : filt
         wake_filter_if fb();
         assign fb.lpo_tick = lpo_tick;
         assign fb.pin_level = wake_pins_in[filter_pin_select[g]];
         assign fb.active = low_leak;
         assign fb.edge_sel = filter_edge_select[g];
         // a detect still in flight is dropped once the filter is switched off
         assign filt_det[g] = fb.detect && low_leak &&
            filter_edge_select[g] != low_leak_wake_pkg::EDGE_OFF;
         wake_pin_filter u_filter (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .bus(fb)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // filter registers; bit 4 holds no storage
   always_ff @(posedge clk_in) begin
      if (chip_reset) begin
         for (int i = 0; i < low_leak_wake_pkg::FILTERS; i++) begin
            filter_edge_select[i] <= low_leak_wake_pkg::EDGE_OFF;
            filter_pin_select[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < low_leak_wake_pkg::FILTERS; i++) begin
            if (filt_wr[i]) begin
               filter_edge_select[i] <=
                  wr_data_in[low_leak_wake_pkg::EDGE_HI:low_leak_wake_pkg::EDGE_LO];
               filter_pin_select[i] <=
                  wr_data_in[low_leak_wake_pkg::SEL_HI:low_leak_wake_pkg::SEL_LO];
            end
         end
      end
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clk_in) begin
      if (chip_reset) begin
         filter_detect_flag <= 2'h0;
      end else begin
         for (int i = 0; i < low_leak_wake_pkg::FILTERS; i++) begin
            if (filt_det[i]) begin
               filter_detect_flag[i] <= 1'b1;
            end else if (filt_wr[i] && wr_data_in[low_leak_wake_pkg::FLAG_BIT]) begin
               filter_detect_flag[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-pin edge setting and unfiltered pin flags
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < low_leak_wake_pkg::PINS; i++) begin
            pin_edge[i] <= low_leak_wake_pkg::EDGE_OFF;
         end
      end else if (wr_en_in && addr_in <= low_leak_wake_pkg::ADDR_PIN_EDGE_LAST) begin
         for (int k = 0; k < 4; k++) begin
            pin_edge[{addr_in[1:0], 2'(k)}] <= wr_data_in[2 * k +: 2];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      pins_prev <= wake_pins_in;
   end

   always_comb begin
      for (int i = 0; i < low_leak_wake_pkg::PINS; i++) begin
         pin_hit[i] = low_leak &&
            low_leak_wake_pkg::edge_hit(pin_edge[i], pins_prev[i], wake_pins_in[i]);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_flag <= 16'h0000;
      end else begin
         for (int i = 0; i < low_leak_wake_pkg::PINS; i++) begin
            if (pin_hit[i]) begin
               pin_flag[i] <= 1'b1;
            end else if (wr_en_in && wr_data_in[i % 8] &&
                         addr_in == (i < 8 ? low_leak_wake_pkg::ADDR_PIN_FLAG_LO
                                           : low_leak_wake_pkg::ADDR_PIN_FLAG_HI)) begin
               pin_flag[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // module sources: no filter, only the enable
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         module_wake_enable <= low_leak_wake_pkg::REG_RESET;
      end else if (wr_en_in && addr_in == low_leak_wake_pkg::ADDR_MOD_ENABLE) begin
         module_wake_enable <= wr_data_in;
      end
   end

   assign module_hit = module_wake_req_in & module_wake_enable & {8{low_leak}};
   // a stale peripheral flag left set wakes at once on entry
   assign wake_any = |pin_hit || |filt_det || |module_hit;

   ////////////////////////////////////////////////////////////////////////////
   // wake response
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wake_irq_out <= 1'b0;
         wake_reset_out <= 1'b0;
      end else begin
         wake_irq_out <= in_lls && wake_any;
         wake_reset_out <= in_vlls && wake_any;
      end
   end

   always_ff @(posedge clk_in) begin
      if (chip_reset) begin
         reset_status_wake_flag <= 1'b0;
      end else if (in_vlls && wake_any) begin
         reset_status_wake_flag <= 1'b1;
      end
   end

   // isolation held through the deep-wake reset until software acks
   always_ff @(posedge clk_in) begin
      if (chip_reset) begin
         io_isolate_out <= 1'b0;
      end else if (in_vlls) begin
         io_isolate_out <= 1'b1;
      end else if (wr_en_in && addr_in == low_leak_wake_pkg::ADDR_STATUS &&
                   wr_data_in[low_leak_wake_pkg::STAT_ACK_BIT]) begin
         io_isolate_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port, data in the cycle after the strobe
   always_comb begin
      next_rd_data = 8'h00;
      if (addr_in <= low_leak_wake_pkg::ADDR_PIN_EDGE_LAST) begin
         for (int k = 0; k < 4; k++) begin
            next_rd_data[2 * k +: 2] = pin_edge[{addr_in[1:0], 2'(k)}];
         end
      end else begin
         case (addr_in)
            low_leak_wake_pkg::ADDR_MOD_ENABLE: next_rd_data = module_wake_enable;
            low_leak_wake_pkg::ADDR_PIN_FLAG_LO: next_rd_data = pin_flag[7:0];
            low_leak_wake_pkg::ADDR_PIN_FLAG_HI: next_rd_data = pin_flag[15:8];
            low_leak_wake_pkg::ADDR_STATUS: begin
               next_rd_data[low_leak_wake_pkg::STAT_WAKE_BIT] = reset_status_wake_flag;
               next_rd_data[low_leak_wake_pkg::STAT_ISO_BIT] = io_isolate_out;
            end
            low_leak_wake_pkg::ADDR_FILT_ONE: next_rd_data = {filter_detect_flag[0],
               filter_edge_select[0], 1'b0, filter_pin_select[0]};
            low_leak_wake_pkg::ADDR_FILT_TWO: next_rd_data = {filter_detect_flag[1],
               filter_edge_select[1], 1'b0, filter_pin_select[1]};
            default: next_rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_en_in) begin
         rd_data_out <= next_rd_data;
      end else begin
         rd_data_out <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_flag_sets: assert property (@(posedge clk_in) disable iff (chip_reset)
      filt_det[0] |=> filter_detect_flag[0])
      else $error("filter one flag missed a detection");

   a_flag_clears: assert property (@(posedge clk_in) disable iff (chip_reset)
      wr_filt_two && wr_data_in[low_leak_wake_pkg::FLAG_BIT] && !filt_det[1]
         |=> !filter_detect_flag[1])
      else $error("filter two flag not cleared by write one");

   a_bit4_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rd_en_in && (addr_in == low_leak_wake_pkg::ADDR_FILT_ONE
         || addr_in == low_leak_wake_pkg::ADDR_FILT_TWO) |=> !rd_data_out[4])
      else $error("reserved filter bit read as one");

   a_off_no_flag: assert property (@(posedge clk_in) disable iff (chip_reset)
      filter_edge_select[0] == low_leak_wake_pkg::EDGE_OFF && !filter_detect_flag[0]
         && !wr_filt_one ##1 filter_edge_select[0] == low_leak_wake_pkg::EDGE_OFF
         |-> !filter_detect_flag[0])
      else $error("disabled filter set its flag");

   a_run_no_wake: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      power_mode_in == low_leak_wake_pkg::MODE_RUN |=> !wake_irq_out && !wake_reset_out)
      else $error("wake response raised in run mode");

   a_lls_module_irq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      power_mode_in == low_leak_wake_pkg::MODE_LLS && |(module_wake_req_in & module_wake_enable)
         |=> wake_irq_out && !wake_reset_out)
      else $error("enabled module request gave no interrupt flow");

   a_vlls_reset_flow: assert property (@(posedge clk_in) disable iff (chip_reset)
      in_vlls && wake_any |=> reset_status_wake_flag && (wake_reset_out || !$past(rst_n_in)))
      else $error("deep wake gave no reset flow");

   a_iso_held: assert property (@(posedge clk_in) disable iff (chip_reset)
      io_isolate_out && !(wr_en_in && addr_in == low_leak_wake_pkg::ADDR_STATUS
         && wr_data_in[low_leak_wake_pkg::STAT_ACK_BIT]) |=> io_isolate_out)
      else $error("isolation released without ack");

   a_filt_kept: assert property (@(posedge clk_in)
      !rst_n_in && deep_wake_reset_in |=> $stable(filter_pin_select[0])
         && $stable(filter_edge_select[1]))
      else $error("filter settings lost on deep-wake reset");

   a_disabled_module: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      power_mode_in == low_leak_wake_pkg::MODE_LLS && module_wake_enable == 8'h00
         && pin_hit == 16'h0000
         && filt_det == 2'h0 |=> !wake_irq_out)
      else $error("disabled module woke the chip");

endmodule

`default_nettype wire

// >>> include/low_leak_wake_pkg.sv
// Purpose: shared constants for the low-leakage wake unit and its pin filters
// Assumes: 40 MHz system clock, byte-wide plain register port
// Notes: register offsets are byte addresses on the plain port
//
// Notes on behaviour
// - filter detect flag, bit 7, sets on filtered wake; write one clears it
// - edge field: 00 off, 01 rising, 10 falling, 11 either edge
// - filter register bit 4 reads zero, writes ignored
// - four-bit pin select routes wake pin 0..15 into the filter
// - filter registers reset by plain chip reset only, kept over deep-wake reset
// - two independent filters, each with own select, edge and flag
// - wake detection acts only in low-leak or very-low-leak stop modes
// - every wake pin has its own off/rising/falling/either edge setting
// - filter needs pin held asserted for 3 low-power clock cycles
// - up to 2 sync cycles, so detection within 5 low-power cycles
// - module wake requests bypass the glitch filter
// - per-module enable bit decides whether module request may wake
// - in low-leak stop, a wake event starts the interrupt flow
// - in very-low-leak modes, wake gives reset flow and sets reset wake flag
// - after deep wake, pins stay isolated until software writes the ack

package low_leak_wake_pkg;

   localparam logic [7:0] ADDR_PIN_EDGE_FIRST = 8'h00;
   localparam logic [7:0] ADDR_PIN_EDGE_LAST = 8'h03;
   localparam logic [7:0] ADDR_MOD_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_PIN_FLAG_LO = 8'h05;
   localparam logic [7:0] ADDR_PIN_FLAG_HI = 8'h06;
   localparam logic [7:0] ADDR_STATUS = 8'h07;
   localparam logic [7:0] ADDR_FILT_ONE = 8'h08;
   localparam logic [7:0] ADDR_FILT_TWO = 8'h09;

   localparam int FLAG_BIT = 7;
   localparam int EDGE_HI = 6;
   localparam int EDGE_LO = 5;
   localparam int SEL_HI = 3;
   localparam int SEL_LO = 0;
   localparam int STAT_WAKE_BIT = 0;
   localparam int STAT_ISO_BIT = 1;
   localparam int STAT_ACK_BIT = 2;

   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY = 2'h3;

   localparam logic [1:0] MODE_RUN = 2'h0;
   localparam logic [1:0] MODE_LLS = 2'h1;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] FILT_CYCLES = 2'h3;
   localparam int FILTERS = 2;
   localparam int PINS = 16;
   localparam int MODULES = 8;

   localparam int CLK_PERIOD_NS = 25;
   localparam int LPO_PERIOD_NS = 1000000;
   localparam int LPO_DIV_CYCLES = LPO_PERIOD_NS / CLK_PERIOD_NS;

   function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                     input logic cur);
      case (sel)
         EDGE_RISE: edge_hit = !prev && cur;
         EDGE_FALL: edge_hit = prev && !cur;
         EDGE_ANY: edge_hit = prev != cur;
         default: edge_hit = 1'b0;
      endcase
   endfunction

endpackage

// >>> include/wake_filter_if.sv
// Purpose: link between the wake unit and one pin glitch filter
// Assumes: both ends on clk_in
// Notes: lpo_tick is a one-cycle enable from the wake unit divider
`timescale 1ns/1ps
`default_nettype none

interface wake_filter_if;
   logic lpo_tick;
   logic pin_level;
   logic active;
   logic [1:0] edge_sel;
   logic detect;
   modport ctl(output lpo_tick, output pin_level, output active, output edge_sel,
               input detect);
   modport flt(input lpo_tick, input pin_level, input active, input edge_sel,
               output detect);
endinterface

`default_nettype wire

// >>> verilog/wake_pin_filter.sv
// Purpose: glitch filter for one selected wake pin
// Assumes: pin level already muxed, lpo_tick one cycle wide
// Notes: detect is a one-cycle pulse on a tick
`timescale 1ns/1ps
`default_nettype none

module wake_pin_filter (
   input wire logic clk_in,
   input wire logic rst_n_in,
   wake_filter_if.flt bus
);

   logic sync_a;
   logic sync_b;
   logic prev;
   logic held;
   logic [1:0] cnt;

   ////////////////////////////////////////////////////////////////////////////
   // sampling keeps running while idle so a new setup settles early
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
      end else if (bus.lpo_tick) begin
         sync_a <= bus.pin_level;
         sync_b <= sync_a;
         prev <= sync_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt <= 2'h0;
         held <= 1'b0;
         bus.detect <= 1'b0;
      end else begin
         bus.detect <= 1'b0;
         if (bus.lpo_tick) begin
            if (bus.edge_sel == low_leak_wake_pkg::EDGE_OFF || !bus.active) begin
               cnt <= 2'h0;
            end else if (cnt == 2'h0) begin
               if (low_leak_wake_pkg::edge_hit(bus.edge_sel, prev, sync_b)) begin
                  cnt <= 2'h1;
                  held <= sync_b;
               end
            end else if (sync_b != held) begin
               cnt <= 2'h0;
            end else if (cnt == low_leak_wake_pkg::FILT_CYCLES) begin
               bus.detect <= 1'b1;
               cnt <= 2'h0;
            end else begin
               cnt <= 2'(cnt + 2'h1);
            end
         end
      end
   end

   a_detect_after_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus.detect |-> $past(cnt) == low_leak_wake_pkg::FILT_CYCLES && $past(bus.lpo_tick)
         && $past(sync_b) == $past(held))
      else $error("filter detect without full hold count");

   a_off_no_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus.edge_sel == low_leak_wake_pkg::EDGE_OFF && bus.lpo_tick |=> cnt == 2'h0)
      else $error("disabled filter still counting");

endmodule

`default_nettype wire

// >>> tb/wake_source_model.sv
// Purpose: far-side model of the wake pins and internal module wake requests
// Assumes: commanded from the bench clock domain
// Notes: all pins rest at one common level; one selected pin is pulsed on request
`timescale 1ns/1ps
`default_nettype none

module wake_source_model (
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [3:0] sel_in,
   input wire logic idle_in,
   input wire logic [7:0] hold_in,
   input wire logic [7:0] req_in,
   output logic [15:0] pins_out,
   output logic [7:0] req_out
);
   logic [7:0] left = 8'h00;
   logic [3:0] pin = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // pulse length counter, reloaded by a new command even mid-pulse
   always_ff @(posedge clk_in) begin
      if (go_in) begin
         left <= hold_in;
         pin <= sel_in;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end

   // pins are plain driven digital levels, never floating
   always_comb begin
      pins_out = {16{idle_in}};
      if (left != 8'h00) pins_out[pin] = !idle_in;
   end

   // requests stay low until raised, so none is pending at stop entry
   assign req_out = req_in;
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the low-leakage wake unit
// Assumes: divider shortened to 4 clocks per low-power tick
// Notes: filter cases run from a table; reset, pin, module and isolation cases follow
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int DIV = 4;
   typedef struct packed {
      logic filt;
      logic [1:0] edge_sel;
      logic [3:0] sel;
      logic idle;
      logic [7:0] hold;
      logic hit;
   } row_t;

   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic deep_wake_reset_in = 1'b0;
   logic [1:0] power_mode_in = 2'h0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00;
   logic wr_en_in = 1'b0;
   logic rd_en_in = 1'b0;
   logic go = 1'b0;
   logic [3:0] go_sel = 4'h0;
   logic idle = 1'b0;
   logic [7:0] hold = 8'h00;
   logic [7:0] req = 8'h00;
   logic [15:0] wake_pins;
   logic [7:0] mod_req;
   logic [7:0] rd_data_out;
   logic wake_irq_out;
   logic wake_reset_out;
   logic io_isolate_out;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int hits;
   int resets;
   logic [7:0] d;
   logic [7:0] cfg;
   logic [7:0] fa;
   logic [7:0] oa;
   row_t r;
   row_t rows [8];

   wake_source_model u_src (.clk_in(clk_in), .go_in(go), .sel_in(go_sel), .idle_in(idle),
      .hold_in(hold), .req_in(req), .pins_out(wake_pins), .req_out(mod_req));

   low_leak_wake_unit #(.LPO_DIV(DIV)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .deep_wake_reset_in(deep_wake_reset_in), .power_mode_in(power_mode_in),
      .wake_pins_in(wake_pins), .module_wake_req_in(mod_req), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .wake_irq_out(wake_irq_out),
      .wake_reset_out(wake_reset_out), .io_isolate_out(io_isolate_out));

   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ceiling well above the roughly 720 cycles the run needs
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= v;
      wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask

   task automatic chkrd(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 d = rd_data_out;
      chk(name, exp, d);
   endtask

   task automatic do_reset(input logic deep);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      deep_wake_reset_in <= deep;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      deep_wake_reset_in <= 1'b0;
   endtask

   task automatic set_mode(input logic [1:0] m);
      @(posedge clk_in);
      power_mode_in <= m;
   endtask

   task automatic pulse(input logic [3:0] s, input logic [7:0] h);
      @(posedge clk_in);
      go <= 1'b1;
      go_sel <= s;
      hold <= h;
      @(posedge clk_in);
      go <= 1'b0;
   endtask

   // counts cycles with each wake output high, sampled once settled
   task automatic watch(input int n);
      hits = 0;
      resets = 0;
      repeat (n) begin
         @(posedge clk_in);
         #1;
         if (wake_irq_out === 1'b1) hits++;
         if (wake_reset_out === 1'b1) resets++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      // filter, edge code, pin, rest level, pulse length, wake expected
      rows = '{
         '{1'b0, 2'h1, 4'h0, 1'b0, 8'h3C, 1'b1},
         '{1'b0, 2'h1, 4'h3, 1'b1, 8'h3C, 1'b0},
         '{1'b0, 2'h2, 4'hF, 1'b1, 8'h3C, 1'b1},
         '{1'b1, 2'h2, 4'h7, 1'b0, 8'h3C, 1'b0},
         '{1'b1, 2'h3, 4'hF, 1'b0, 8'h3C, 1'b1},
         '{1'b1, 2'h3, 4'h0, 1'b1, 8'h3C, 1'b1},
         '{1'b0, 2'h0, 4'h5, 1'b0, 8'h3C, 1'b0},
         '{1'b1, 2'h1, 4'h9, 1'b0, 8'h06, 1'b0}};
      do_reset(1'b0);
      foreach (rows[i]) begin
         r = rows[i];
         cfg = {1'b0, r.edge_sel, 1'b0, r.sel};
         fa = r.filt ? 8'h09 : 8'h08;
         oa = r.filt ? 8'h08 : 8'h09;
         set_mode(2'h0);
         wr(oa, 8'h80);
         wr(fa, 8'h80 | cfg);
         @(posedge clk_in);
         idle <= r.idle;
         // filter settles before stop entry
         repeat (5 * DIV + 4) @(posedge clk_in);
         set_mode(2'h1);
         pulse(r.sel, r.hold);
         watch(9 * DIV);
         chk("filter wake", {7'h0, r.hit}, {7'h0, hits != 0});
         chk("reset flow in shallow stop", 8'h00, 8'(resets));
         set_mode(2'h0);
         chkrd("filter reg", fa, {r.hit, cfg[6:0]});
         chkrd("other filter", oa, 8'h00);
         wr(fa, 8'h80 | cfg);
         chkrd("flag cleared", fa, cfg);
         $display("row %0d done", i);
      end

      do_reset(1'b0);
      chkrd("filter one reset", 8'h08, 8'h00);
      wr(8'h08, 8'h7F);
      wr(8'h09, 8'h35);
      chkrd("reserved bit", 8'h08, 8'h6F);
      // read data stands one cycle only, then drops back to zero
      @(posedge clk_in);
      #1 chk("read data drop", 8'h00, rd_data_out);
      chkrd("unmapped", 8'h20, 8'h00);
      do_reset(1'b1);
      chkrd("kept over deep reset", 8'h09, 8'h25);
      do_reset(1'b0);
      chkrd("cleared by chip reset", 8'h08, 8'h00);
      $display("reset test done");

      wr(8'h00, 8'h01);
      @(posedge clk_in);
      idle <= 1'b0;
      repeat (4) @(posedge clk_in);
      set_mode(2'h1);
      pulse(4'h0, 8'h1E);
      watch(4);
      chk("pin edge wake", 8'h01, {7'h0, hits != 0});
      set_mode(2'h0);
      chkrd("pin flag", 8'h05, 8'h01);
      wr(8'h05, 8'h01);
      chkrd("pin flag cleared", 8'h05, 8'h00);
      wr(8'h00, 8'h00);
      $display("pin edge test done");

      wr(8'h04, 8'h01);
      set_mode(2'h1);
      @(posedge clk_in);
      req <= 8'h02;
      watch(3);
      chk("masked module", 8'h00, 8'(hits));
      @(posedge clk_in);
      req <= 8'h01;
      @(posedge clk_in);
      #1 chk("module irq", 8'h01, {7'h0, wake_irq_out});
      set_mode(2'h0);
      watch(3);
      chk("run mode ignores", 8'h00, 8'(hits));
      @(posedge clk_in);
      req <= 8'h00;
      set_mode(2'h2);
      @(posedge clk_in);
      req <= 8'h01;
      watch(2);
      chk("reset flow", 8'h01, {7'h0, resets != 0});
      chk("isolated", 8'h01, {7'h0, io_isolate_out});
      @(posedge clk_in);
      req <= 8'h00;
      wr(8'h07, 8'h04);
      #1 chk("ack in deep mode", 8'h01, {7'h0, io_isolate_out});
      set_mode(2'h0);
      chkrd("status", 8'h07, 8'h03);
      // pin setup untouched since entry, so releasing isolation is safe
      wr(8'h07, 8'h04);
      @(posedge clk_in);
      #1 chk("released", 8'h00, {7'h0, io_isolate_out});
      chkrd("status after ack", 8'h07, 8'h01);
      $display("module and isolation test done");
      print_verdict();
   end
endmodule

`default_nettype wire
